// >>> src/multiphase_pwm_phase_sequencer.sv
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// Overview of operation
// [R1] No grounded sense: run four phases
// [R2] Only phase four grounded: three phases
// [R3] Phases three and four grounded: two phases
// [R4] Sense comparators mark grounded phases disabled
// [R5] Detection lasts two master cycles
// [R6] Phases one, two held low during detection
// [R7] Grounded phases stay off, others switch
// [R8] Per-phase rate is master over count
// [R9] Each phase may reach near-full duty
// [R10] Phase on-times may overlap
// [R11] Disabled or lockout: soft-start held grounded
// [R12] Enabled, no lockout: soft-start charges
// [R13] Disabled or lockout: all phases low
// [R14] Disabled or lockout: driver enable low
// [R15] Enable low: output good flag low
// [R16] Round-robin starts, one per master cycle
// [R17] Detection repeats on every re-enable
module multiphase_pwm_phase_sequencer (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Supervisory inputs
   input wire logic converter_enable_i,
   input wire logic supply_undervoltage_lockout_i,
   input wire logic phase_sense_3_i,  // High: phase three pin below threshold
   input wire logic phase_sense_4_i,  // High: phase four pin below threshold
   input wire logic output_in_window_i,
   // Power-stage side
   output logic phase_out_1_o,
   output logic phase_out_2_o,
   output logic phase_out_3_o,
   output logic phase_out_4_o,
   output logic detect_bias_o,        // Weak bias on phases three, four
   output logic driver_enable_out_o,
   output logic output_good_flag_o,
   output logic soft_start_hold_o,
   output logic soft_start_charge_o
);
   import pwm_seq_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   seq_state_t state;               // Sequencer state
   seq_state_t next_state;          // Its next value
   logic run_ok;                    // Enabled and supply good
   logic [15:0] period;             // Master period in clocks
   logic [15:0] period_eff;         // Period, never below one
   logic [15:0] on_time [NUM_PHASES]; // Per-phase on-time
   logic [15:0] mcnt;               // Master clock divider
   logic tick;                      // Last clock of a master cycle
   logic [1:0] dcnt;                // Master ticks seen in detection
   logic det_end;                   // Final detection tick
   logic gnd3;                      // Phase three found grounded
   logic gnd4;                      // Phase four found grounded
   logic [2:0] active_cnt;          // Configured phase count
   logic [1:0] ptr;                 // Round-robin pointer
   logic [1:0] next_ptr;            // Its next value
   logic [NUM_PHASES-1:0] pwm_vec;  // Channel outputs
   logic ack;                       // Bus acknowledge flop
   logic [31:0] rd_data;            // Read mux
   logic [31:0] status_word;        // Status register image
   logic [5:0] idx;                 // Word index on the bus
   logic hit_period;                // Decodes
   logic hit_status;
   logic hit_ontime;
   logic [1:0] ontime_sel;
   logic wr_go;                     // Write takes effect

   phase_ctl_if ctl [NUM_PHASES] ();

   // ------------------------------------------------------------
   // Enable qualification
   // ------------------------------------------------------------
   assign run_ok = converter_enable_i && !supply_undervoltage_lockout_i;

   // ------------------------------------------------------------
   // Master oscillator
   // ------------------------------------------------------------
   assign period_eff = (period == 16'h0000) ? 16'h0001 : period;
   assign tick = (mcnt >= period_eff - 16'h0001);

   // Divider restarts while off so detection is aligned to enable
   always_ff @(posedge clk_i) begin
      if (rst_i || state == SEQ_OFF) begin
         mcnt <= 16'h0000;
      end else if (tick) begin
         mcnt <= 16'h0000;
      end else begin
         mcnt <= mcnt + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Sequencer state machine
   // ------------------------------------------------------------
   assign det_end = (state == SEQ_DETECT) && tick && (dcnt == DETECT_LAST);

   always_comb begin
      next_state = state;
      unique case (state)
         SEQ_OFF: begin
            // [R17] Fresh detection on every exit
            if (run_ok) begin
               next_state = SEQ_DETECT;
            end
         end
         SEQ_DETECT: begin
            // [R5] Two master cycles
            if (det_end) begin
               next_state = SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            next_state = SEQ_RUN;
         end
         default: begin
            next_state = SEQ_OFF;
         end
      endcase
      // [R13] Any loss of enable wins
      if (!run_ok) begin
         next_state = SEQ_OFF;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= SEQ_OFF;
      end else begin
         state <= next_state;
      end
   end

   // Detection tick counter
   always_ff @(posedge clk_i) begin
      if (rst_i || state != SEQ_DETECT) begin
         dcnt <= 2'h0;
      end else if (tick) begin
         dcnt <= dcnt + 2'h1;
      end
   end

   // ------------------------------------------------------------
   // Phase detection
   // ------------------------------------------------------------
   // Sampling at the last detection tick lets the pin bias settle
   // for nearly two master cycles before the decision.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gnd3 <= 1'b0;
         gnd4 <= 1'b0;
      end else if (det_end) begin
         // [R4] Comparator marks phase disabled
         gnd3 <= phase_sense_3_i;
         gnd4 <= phase_sense_4_i;
      end
   end

   // A grounded phase three with phase four free is not a listed
   // option; it falls back to two phases.
   // [R1] [R2] [R3] Phase count choice
   assign active_cnt = gnd3 ? 3'h2 : (gnd4 ? 3'h3 : 3'h4);

   // Bias drives phases three and four only while detecting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         detect_bias_o <= 1'b0;
      end else begin
         detect_bias_o <= (next_state == SEQ_DETECT);
      end
   end

   // ------------------------------------------------------------
   // Round-robin phase starts
   // ------------------------------------------------------------
   // [R16] Wrap at the configured count
   assign next_ptr = ({1'b0, ptr} >= active_cnt - 3'h1) ? 2'h0 : ptr + 2'h1;

   always_ff @(posedge clk_i) begin
      if (rst_i || state != SEQ_RUN) begin
         ptr <= 2'h0;
      end else if (tick) begin
         // [R8] One phase per master cycle
         ptr <= next_ptr;
      end
   end

   // ------------------------------------------------------------
   // Phase channels
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_PHASES; g++) begin : g_ch
         // [R6] [R7] Only configured phases run
         assign ctl[g].run = run_ok && (state == SEQ_RUN) && (3'(g) < active_cnt);
         assign ctl[g].start = tick && (ptr == 2'(g));
         assign ctl[g].on_time = on_time[g];
         assign pwm_vec[g] = ctl[g].pwm;
         // [R10] Channels are independent, on-times may overlap
         phase_channel u_ch (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ctl(ctl[g])
         );
      end
   endgenerate

   assign phase_out_1_o = pwm_vec[0];
   assign phase_out_2_o = pwm_vec[1];
   assign phase_out_3_o = pwm_vec[2];
   assign phase_out_4_o = pwm_vec[3];

   // ------------------------------------------------------------
   // Supervisory outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         driver_enable_out_o <= 1'b0;
         output_good_flag_o <= 1'b0;
         soft_start_hold_o <= 1'b1;
         soft_start_charge_o <= 1'b0;
      end else begin
         // [R14] Drivers off when disabled
         driver_enable_out_o <= run_ok;
         // [R15] Good flag needs enable
         output_good_flag_o <= run_ok && (state == SEQ_RUN) && output_in_window_i;
         // [R11] [R12] Soft-start node control
         soft_start_hold_o <= !run_ok;
         soft_start_charge_o <= run_ok;
      end
   end

   // ------------------------------------------------------------
   // Wishbone register access
   // ------------------------------------------------------------
   assign idx = wb_adr_i[7:2];
   assign hit_period = (idx == PERIOD_OFS[7:2]);
   assign hit_status = (idx == STATUS_OFS[7:2]);
   assign hit_ontime = (idx >= ONTIME_OFS[7:2]) && (idx < STATUS_OFS[7:2]);
   assign ontime_sel = 2'(idx - ONTIME_OFS[7:2]);
   // Write lands on the edge the master sees ack
   assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack;

   assign status_word = (32'(state) << ST_STATE_LSB) | (32'(active_cnt) << ST_COUNT_LSB)
                      | (32'(gnd3) << ST_GND3_BIT) | (32'(gnd4) << ST_GND4_BIT)
                      | (32'(soft_start_charge_o) << ST_SS_BIT) | (32'(pwm_vec) << ST_PWM_LSB);

   // Unmapped words acknowledge and read zero
   assign rd_data = hit_period ? {16'h0000, period} :
                    hit_ontime ? {16'h0000, on_time[ontime_sel]} :
                    hit_status ? status_word : 32'h0000_0000;

   // Ack one clock after the request, dropped the clock after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack <= wb_cyc_i && wb_stb_i && !ack;
         wb_dat_o <= rd_data;
      end
   end
   assign wb_ack_o = ack;

   // Period register with byte lanes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         period <= PERIOD_RST;
      end else if (wr_go && hit_period) begin
         if (wb_sel_i[0]) begin
            period[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            period[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // On-time registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_PHASES; i++) begin
            on_time[i] <= ONTIME_RST;
         end
      end else if (wr_go && hit_ontime) begin
         if (wb_sel_i[0]) begin
            on_time[ontime_sel][7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            on_time[ontime_sel][15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence det_done_s;
      det_end && run_ok;
   endsequence

   sequence off_s;
      !run_ok;
   endsequence

   four_phase_a: assert property (det_done_s and (!phase_sense_3_i && !phase_sense_4_i) |=> // [R1]
      state == SEQ_RUN && active_cnt == 3'h4)
      else $error("four-phase setting not taken");
   three_phase_a: assert property (det_done_s and (!phase_sense_3_i && phase_sense_4_i) |=> // [R2]
      state == SEQ_RUN && active_cnt == 3'h3)
      else $error("three-phase setting not taken");
   two_phase_a: assert property (det_done_s and (phase_sense_3_i && phase_sense_4_i) |=> // [R3]
      active_cnt == 3'h2 && !phase_out_3_o)
      else $error("two-phase setting not taken");
   detect_len_a: assert property ($rose(state == SEQ_RUN) |-> // [R5]
      $past(state == SEQ_DETECT) && $past(dcnt) == DETECT_LAST && $past(tick))
      else $error("detection did not last two master cycles");
   detect_hold_a: assert property (state == SEQ_DETECT |-> !phase_out_1_o && !phase_out_2_o) // [R6]
      else $error("phase one or two switched during detection");
   grounded_off_a: assert property (state == SEQ_RUN && gnd4 |-> !phase_out_4_o) // [R7]
      else $error("grounded phase four switched");
   phase_low_a: assert property (off_s |=> pwm_vec == 4'h0) // [R13]
      else $error("phase output high while disabled");
   soft_hold_a: assert property (off_s |=> soft_start_hold_o && !soft_start_charge_o) // [R11]
      else $error("soft-start not held while disabled");
   soft_go_a: assert property (run_ok |=> soft_start_charge_o && !soft_start_hold_o) // [R12]
      else $error("soft-start not released when enabled");
   drv_off_a: assert property (off_s |=> !driver_enable_out_o) // [R14]
      else $error("driver enable high while disabled");
   good_low_a: assert property (!converter_enable_i |=> !output_good_flag_o) // [R15]
      else $error("good flag high with enable low");
   rr_wrap_a: assert property (state == SEQ_RUN && tick && {1'b0, ptr} == active_cnt - 3'h1 // [R16]
      && next_state == SEQ_RUN |=> ptr == 2'h0)
      else $error("round-robin did not wrap at phase count");
   redetect_a: assert property (state == SEQ_OFF && run_ok |=> state == SEQ_DETECT) // [R17]
      else $error("detection not restarted on enable");
endmodule

// >>> src/pwm_seq_pkg.sv
package pwm_seq_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;        // System clock period
   localparam int MASTER_PERIOD_NS = 1000;   // Default master oscillator period
   localparam logic [15:0] PERIOD_RST = 16'(MASTER_PERIOD_NS / CLK_PERIOD_NS);
   localparam logic [1:0] DETECT_LAST = 2'h1; // Detection spans master ticks 0 and 1
   localparam int NUM_PHASES = 4;

   // ------------------------------------------------------------
   // Register map (byte offsets)
   // ------------------------------------------------------------
   localparam logic [7:0] PERIOD_OFS = 8'h00;  // Master period in clocks
   localparam logic [7:0] ONTIME_OFS = 8'h04;  // First of four on-time words
   localparam logic [7:0] STATUS_OFS = 8'h14;  // Read-only status
   localparam logic [15:0] ONTIME_RST = 16'h0000;

   // Status field positions
   localparam int ST_STATE_LSB = 0;
   localparam int ST_COUNT_LSB = 2;
   localparam int ST_GND3_BIT = 5;
   localparam int ST_GND4_BIT = 6;
   localparam int ST_SS_BIT = 7;
   localparam int ST_PWM_LSB = 8;

   // Sequencer states
   typedef enum logic [1:0] {
      SEQ_OFF = 2'b00,
      SEQ_DETECT = 2'b01,
      SEQ_RUN = 2'b10
   } seq_state_t;
endpackage

// >>> src/phase_ctl_if.sv
`timescale 1ns/1ps
// Sequencer-to-channel control bundle
interface phase_ctl_if;
   logic start;          // One-cycle start of an on-time
   logic run;            // Channel may switch
   logic [15:0] on_time; // On-time in clocks
   logic pwm;            // Channel output
   modport seq(output start, output run, output on_time, input pwm);
   modport chan(input start, input run, input on_time, output pwm);
endinterface

// >>> src/phase_channel.sv
`timescale 1ns/1ps
module phase_channel (
   input wire logic clk_i,
   input wire logic rst_i,
   phase_ctl_if.chan ctl
);
   import pwm_seq_pkg::*;

   logic [15:0] left; // Clocks of on-time still to run
   logic pwm;         // Output flop

   // ------------------------------------------------------------
   // On-time timer
   // ------------------------------------------------------------
   // A new start reloads the timer even while high, so an on-time
   // as long as the switching period gives a steady high level.
   always_ff @(posedge clk_i) begin
      if (rst_i || !ctl.run) begin
         left <= 16'h0000;
         pwm <= 1'b0;
      end else if (ctl.start) begin
         // [R9] Independent reload
         left <= ctl.on_time;
         pwm <= (ctl.on_time != 16'h0000);
      end else if (left != 16'h0000) begin
         left <= left - 16'h0001;
         pwm <= (left > 16'h0001);
      end
   end

   assign ctl.pwm = pwm;
endmodule

// >>> sim/gate_driver_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Gate driver stages and phase pin straps
// ------------------------------------------------------------
module gate_driver_model (
   input wire logic [3:0] phase_i,  // Logic-level phase commands
   input wire logic bias_i,         // Weak detection bias on pins three, four
   input wire logic drv_en_i,       // Driver enable from the controller
   input wire logic strap_3_i,      // Pin three tied to ground on the board
   input wire logic strap_4_i,      // Pin four tied to ground on the board
   output logic sense_3_o,          // Pin three below threshold
   output logic sense_4_o,          // Pin four below threshold
   output logic [3:0] high_side_o   // High-side switch state per stage
);
   // A strap always wins; the bias lifts a free pin above threshold,
   // otherwise the pin simply follows its low or high command
   // threshold compare
   assign sense_3_o = strap_3_i | (!bias_i & !phase_i[2]);
   assign sense_4_o = strap_4_i | (!bias_i & !phase_i[3]);
   // Without enable every high-side switch stays off, whatever the command
   // driver off gating
   assign high_side_o = drv_en_i ? phase_i : 4'h0;
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   import pwm_seq_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int P = 4;         // Short master period keeps runs brief
   localparam int LIMIT = 5000;  // Cycle ceiling for the whole run
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000;
   logic en = 1'b0;              // Converter enable
   logic supply_undervoltage_lockout = 1'b0;            // Supply lockout
   logic win = 1'b0;             // Output in window
   logic strap3 = 1'b0;
   logic strap4 = 1'b0;
   wire [31:0] rdat;
   wire [3:0] ph;
   wire [3:0] hs;
   wire ack, s3, s4, bias, drv_en, good, ss_hold, ss_chg;
   int fail_count = 0;
   int checks = 0;
   int cyc_count = 0;
   int rise_cnt[4], first_rise[4], last_rise[4], hi_len[4], last_hi[4];
   int order[$];                 // Phase index of every rising edge
   int en_time;                  // Cycle at which start was allowed
   bit overlap;                  // Two phases seen high together
   logic [3:0] prev_ph = 4'h0;
   logic prev_ok = 1'b0;

   multiphase_pwm_phase_sequencer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .converter_enable_i(en), .supply_undervoltage_lockout_i(supply_undervoltage_lockout), .phase_sense_3_i(s3),
      .phase_sense_4_i(s4), .output_in_window_i(win), .phase_out_1_o(ph[0]), .phase_out_2_o(ph[1]),
      .phase_out_3_o(ph[2]), .phase_out_4_o(ph[3]), .detect_bias_o(bias), .driver_enable_out_o(drv_en),
      .output_good_flag_o(good), .soft_start_hold_o(ss_hold), .soft_start_charge_o(ss_chg));

   gate_driver_model u_drv (.phase_i(ph), .bias_i(bias), .drv_en_i(drv_en), .strap_3_i(strap3),
      .strap_4_i(strap4), .sense_3_o(s3), .sense_4_o(s4), .high_side_o(hs));

   always #5 clk_i = ~clk_i;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Phase count from the straps; pin three alone also means two
   function automatic int exp_count(input logic g3, input logic g4);
      return g3 ? 2 : (g4 ? 3 : 4);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task stop_test;
      $display("checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One classic cycle; holds everything until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'h3;
      // Wait for the answer; only the bench ceiling ends a hang
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      // Ack stands in the clock after the taking edge
      check(n, 2, "bus answer latency");
   endtask

   task clear_mon;
      overlap = 0;
      order.delete();
      for (int i = 0; i < 4; i++) begin
         rise_cnt[i] = 0;
         hi_len[i] = 0;
         last_hi[i] = 0;
      end
   endtask

   // ------------------------------------------------------------
   // Phase monitor and cycle ceiling
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      cyc_count++;
      if ($countones(ph) >= 2) begin
         overlap = 1;
      end
      for (int i = 0; i < 4; i++) begin
         if (ph[i] === 1'b1 && prev_ph[i] === 1'b0) begin
            if (rise_cnt[i] == 0) begin
               first_rise[i] = cyc_count;
            end
            last_rise[i] = cyc_count;
            rise_cnt[i]++;
            order.push_back(i);
         end
         if (ph[i] === 1'b1) begin
            hi_len[i]++;
         end else if (prev_ph[i] === 1'b1) begin
            last_hi[i] = hi_len[i];
            hi_len[i] = 0;
         end
      end
      if (en && !supply_undervoltage_lockout && !prev_ok) begin
         en_time = cyc_count;
      end
      prev_ok = en && !supply_undervoltage_lockout;
      prev_ph = ph;
      if (cyc_count > LIMIT) begin
         fail_count++;
         stop_test;
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic g3, g4;
      int cnt, ot, d;
      void'($urandom(98));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, PERIOD_OFS, 32'h0000_0000, r);
      check(r, 32'h0000_0064, "period reset");
      for (int i = 0; i < 4; i++) begin
         wb(1'b0, ONTIME_OFS + 8'(4 * i), 32'h0000_0000, r);
         check(r, 32'h0000_0000, "on-time reset");
      end
      // Unmapped word: write dropped, read gives zero
      wb(1'b1, 8'h20, 32'hFFFF_FFFF, r);
      wb(1'b0, 8'h20, 32'h0000_0000, r);
      check(r, 32'h0000_0000, "unmapped read");
      wb(1'b1, PERIOD_OFS, 32'hABCD_0004, r);
      wb(1'b0, PERIOD_OFS, 32'h0000_0000, r);
      check(r, 32'h0000_0004, "period width");
      check({ss_hold, ss_chg, drv_en, good, ph}, 8'h80, "idle outputs");
      // Every strap pattern; odd passes start through lockout release
      for (int k = 0; k < 4; k++) begin
         g3 = (k == 2) || (k == 3);
         g4 = (k == 1) || (k == 2);
         cnt = exp_count(g3, g4);
         ot = P + 1 + int'($urandom % (P * cnt - P - 1));
         for (int i = 0; i < 4; i++) begin
            wb(1'b1, ONTIME_OFS + 8'(4 * i), 32'(ot), r);
         end
         @(posedge clk_i);
         strap3 <= g3;
         strap4 <= g4;
         win <= 1'($urandom);
         supply_undervoltage_lockout <= 1'(k % 2);
         en <= 1'(k % 2);
         @(negedge clk_i);
         clear_mon();
         @(posedge clk_i);
         en <= 1'b1;
         supply_undervoltage_lockout <= 1'b0;
         repeat (3) @(posedge clk_i);
         check({bias, ph[1:0]}, 3'b100, "detect bias");
         repeat (2 * P + 5 * P * cnt) @(posedge clk_i);
         wb(1'b0, STATUS_OFS, 32'h0000_0000, r);
         check(r[7:0], {1'b1, g4, g3, 3'(cnt), 2'b10}, "status");
         check({ss_hold, ss_chg, drv_en, good}, {3'b011, win}, "run flags");
         for (int i = 0; i < 4; i++) begin
            if (i < cnt) begin
               check(last_rise[i] - first_rise[i], (rise_cnt[i] - 1) * P * cnt, "phase rate");
            end else begin
               check(rise_cnt[i], 0, "grounded phase");
            end
         end
         check(rise_cnt[0] >= 4, 1'b1, "phase switching");
         check(last_hi[0], ot, "on time");
         check(overlap, 1'b1, "overlap");
         for (int j = 0; j < order.size(); j++) begin
            check(order[j], j % cnt, "start order");
         end
         // Enable edge, two master cycles of detection, then a third up to the first run tick
         d = first_rise[0] - en_time;
         check(d, 3 * P + 1, "detect length");
         @(posedge clk_i);
         if (k % 2 == 1) begin
            supply_undervoltage_lockout <= 1'b1;
         end else begin
            en <= 1'b0;
         end
         repeat (3) @(posedge clk_i);
         check({ss_hold, ss_chg, drv_en, good, ph, hs}, 12'h800, "disabled");
         en <= 1'b0;
         supply_undervoltage_lockout <= 1'b0;
      end
      stop_test;
   end
endmodule
